// file: design/trig_pwm_timer.sv
// Triggered PWM timer channel with AHB-Lite register slave
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
// How it works
// - Mode code 010 selects triggered PWM
// - Enable set: counter idles awaiting trigger
// - First trigger clears FFFFH to 0000H, counts
// - Running trigger restarts counter, toggles half-duty
// - Every trigger drives pulse output high unless width is zero
// - Width times clock active; cycle plus one period
// - Cycle match: next step irq and clear
// - Width irq in cycle counter equals width
// - Buffers load only at cycle clear, or track registers while mode is off
// - Width register write arms buffer transfer
// - Width zero gives 0%, both irqs together
// - Width cycle plus one gives 100%
// - Trigger after width irq restarts, asserts output
// - Trigger before width match suppresses width irq
// - Trigger after cycle irq clears, keeps counting
// - Trigger before cycle match suppresses cycle irq
// - External edge or soft bit triggers
// - Soft trigger adds 50% half-duty wave
// - Third channel ignores external trigger edge
module trig_pwm_timer
   import trig_pwm_pkg::*;
#(
   parameter bit THIRD_CHANNEL = 1'b0
)(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Count clock tick from prescaler
   input  wire logic        count_tick,
   // Link pins
   input  wire logic        ext_trigger_input,
   output logic             pulse_output,
   output logic             half_duty_output,
   // Match events
   output logic             cycle_match_irq,
   output logic             width_match_irq
);
   typedef struct packed {
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] rdata;
      logic [2:0]  mode;
      logic        enable;
      logic [1:0]  edge_sel;
      logic        soft_pend;
      logic [15:0] cycle_cmp;
      logic [15:0] width_cmp;
      logic [15:0] cycle_buf;
      logic [15:0] width_buf;
      logic        armed;
      logic        running;
      logic        cyc_hit;
      logic [15:0] count;
      logic        pulse;
      logic        half;
      logic        soft_used;
      logic        cyc_irq;
      logic        wid_irq;
      logic [2:0]  trig_sync;
   } state_t;

   state_t st_reg;
   state_t st_next;

   logic        addr_ok;
   logic        trig_edge;
   logic        mode_on;
   logic        trigger;
   logic [31:0] wval;
   logic [15:0] cnt_inc;

   assign addr_ok   = hsel && hready && htrans == HTRANS_NONSEQ;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = st_reg.rdata;
   assign pulse_output     = st_reg.pulse;
   assign half_duty_output = st_reg.half;
   assign cycle_match_irq  = st_reg.cyc_irq;
   assign width_match_irq  = st_reg.wid_irq;
   assign mode_on = st_reg.enable && st_reg.mode == MODE_TRIG_PWM;
   assign wval    = hwdata;
   assign cnt_inc = st_reg.count + 16'h0001;

   always_comb begin
      unique case (st_reg.edge_sel)
         EDGE_RISE: trig_edge = st_reg.trig_sync[1] & ~st_reg.trig_sync[2];
         EDGE_FALL: trig_edge = ~st_reg.trig_sync[1] & st_reg.trig_sync[2];
         EDGE_BOTH: trig_edge = st_reg.trig_sync[1] ^ st_reg.trig_sync[2];
         default:   trig_edge = 1'b0;
      endcase
   end

   // Triggers only act on a count step; soft trigger waits for one
   assign trigger = count_tick && mode_on &&
      ((trig_edge && !THIRD_CHANNEL) || st_reg.soft_pend);

   always_comb begin
      st_next = st_reg;
      st_next.trig_sync = {st_reg.trig_sync[1:0], ext_trigger_input};
      st_next.cyc_irq = 1'b0;
      st_next.wid_irq = 1'b0;
      // Bus data phase
      if (st_reg.wr_pend) begin
         unique case (st_reg.wr_addr)
            OFS_CTRL0: begin
               st_next.mode   = wval[CTL0_MODE_LSB +: 3];
               st_next.enable = wval[CTL0_ENABLE_BIT];
            end
            OFS_CTRL1: begin
               st_next.edge_sel = wval[CTL1_EDGE_LSB +: 2];
               if (wval[CTL1_SOFT_TRIG])
                  st_next.soft_pend = 1'b1;
            end
            OFS_CYCLE: st_next.cycle_cmp = wval[15:0];
            OFS_WIDTH: begin
               st_next.width_cmp = wval[15:0];
               st_next.armed     = 1'b1;
            end
            default: ;
         endcase
      end
      st_next.wr_pend = addr_ok && hwrite;
      if (addr_ok)
         st_next.wr_addr = haddr;
      if (addr_ok && !hwrite) begin
         unique case (haddr)
            OFS_CTRL0: st_next.rdata = {24'h00_0000, st_reg.enable,
                                        4'h0, st_reg.mode};
            OFS_CTRL1: st_next.rdata = {29'h0000_0000, st_reg.edge_sel,
                                        1'b0};
            OFS_CYCLE: st_next.rdata = {16'h0000, st_reg.cycle_cmp};
            OFS_WIDTH: st_next.rdata = {16'h0000, st_reg.width_cmp};
            OFS_STATUS: st_next.rdata = {28'h000_0000, st_reg.half,
                                         st_reg.pulse, st_reg.armed,
                                         st_reg.running};
            OFS_COUNT: st_next.rdata = {16'h0000, st_reg.count};
            default:   st_next.rdata = 32'h0000_0000;
         endcase
      end
      // Counter engine
      if (!mode_on) begin
         st_next.running   = 1'b0;
         st_next.count     = CNT_IDLE;
         st_next.pulse     = 1'b0;
         st_next.cyc_hit   = 1'b0;
         st_next.soft_used = 1'b0;
         st_next.cycle_buf = st_reg.cycle_cmp;
         st_next.width_buf = st_reg.width_cmp;
         st_next.armed     = 1'b0;
         st_next.soft_pend = 1'b0;
      end else if (trigger) begin
         // Trigger wins over any pending match: irqs suppressed
         st_next.count   = CNT_ZERO;
         st_next.running = 1'b1;
         st_next.cyc_hit = 1'b0;
         st_next.pulse   = st_reg.width_buf != CNT_ZERO;
         st_next.soft_pend = 1'b0;
         if (st_reg.soft_pend)
            st_next.soft_used = 1'b1;
         if (st_reg.running)
            st_next.half = ~st_reg.half;
      end else if (count_tick && st_reg.running) begin
         if (st_reg.cyc_hit) begin
            st_next.count   = CNT_ZERO;
            st_next.cyc_hit = 1'b0;
            st_next.cyc_irq = 1'b1;
            if (st_reg.armed) begin
               st_next.cycle_buf = st_reg.cycle_cmp;
               st_next.width_buf = st_reg.width_cmp;
               st_next.armed     = 1'b0;
            end
            st_next.pulse = (st_reg.armed ? st_reg.width_cmp
                             : st_reg.width_buf) != CNT_ZERO;
            if (st_reg.width_buf == CNT_ZERO)
               st_next.wid_irq = 1'b1;
            if (st_reg.soft_used)
               st_next.half = ~st_reg.half;
         end else begin
            st_next.count = cnt_inc;
            if (cnt_inc == st_reg.cycle_buf)
               st_next.cyc_hit = 1'b1;
            if (cnt_inc == st_reg.width_buf) begin
               st_next.pulse   = 1'b0;
               st_next.wid_irq = 1'b1;
            end
         end
      end
      // Set wins over clear for the soft trigger latch while mode is on
      if (st_reg.wr_pend && st_reg.wr_addr == OFS_CTRL1 &&
          wval[CTL1_SOFT_TRIG] && mode_on)
         st_next.soft_pend = 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '{wr_pend:   1'b0,
                     wr_addr:   8'h00,
                     rdata:     32'h0000_0000,
                     mode:      3'h0,
                     enable:    1'b0,
                     edge_sel:  EDGE_NONE,
                     soft_pend: 1'b0,
                     cycle_cmp: CMP_RESET,
                     width_cmp: CMP_RESET,
                     cycle_buf: CMP_RESET,
                     width_buf: CMP_RESET,
                     armed:     1'b0,
                     running:   1'b0,
                     cyc_hit:   1'b0,
                     count:     CNT_IDLE,
                     pulse:     1'b0,
                     half:      1'b0,
                     soft_used: 1'b0,
                     cyc_irq:   1'b0,
                     wid_irq:   1'b0,
                     trig_sync: 3'h0};
      end else begin
         st_reg <= st_next;
      end
   end

   // Cycle match leads to clear and irq on next count step
   sequence cyc_hit_s;
      mode_on && count_tick && st_reg.running && !trigger &&
      st_reg.count == st_reg.cycle_buf && st_reg.cyc_hit;
   endsequence
   cycle_irq_step_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      cyc_hit_s |=> cycle_match_irq && st_reg.count == CNT_ZERO)
      else $error("cycle match did not clear with irq");
   trig_clear_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      trigger |=> st_reg.count == CNT_ZERO && st_reg.running)
      else $error("trigger did not clear counter");
   trig_high_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      trigger && st_reg.width_buf != CNT_ZERO |=> pulse_output)
      else $error("trigger did not raise pulse output");
   retrig_toggle_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      trigger && st_reg.running |=> half_duty_output != $past(half_duty_output))
      else $error("restart did not toggle half duty output");
   trig_no_irq_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      trigger |=> !cycle_match_irq && !width_match_irq)
      else $error("irq raised on trigger step");
   width_match_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      width_match_irq && st_reg.count != CNT_ZERO |->
      st_reg.count == st_reg.width_buf && !pulse_output)
      else $error("width irq off the match cycle");
   idle_wait_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !mode_on |=> st_reg.count == CNT_IDLE && !st_reg.running)
      else $error("counter not idle without mode");
   buf_hold_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      mode_on && !cycle_match_irq |-> $stable(st_reg.width_buf) ||
      !$past(mode_on))
      else $error("buffer changed outside cycle clear");
   third_ext_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      THIRD_CHANNEL && !st_reg.soft_pend |-> !trigger)
      else $error("third channel took external trigger");

   // Plain counting step: no trigger, no pending clear
   sequence count_step_s;
      mode_on && count_tick && st_reg.running && !trigger &&
      !st_reg.cyc_hit;
   endsequence

   // Mode gating and idle wait
   mode_off_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !mode_on |=> !pulse_output && !cycle_match_irq && !width_match_irq)
      else $error("outputs active outside triggered mode");
   idle_low_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      mode_on && !st_reg.running |-> !pulse_output)
      else $error("pulse output active while waiting");
   wait_idle_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      mode_on && !st_reg.running && !trigger |=> st_reg.count == CNT_IDLE)
      else $error("counter moved before trigger");

   // First trigger and trigger sources
   first_idle_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      trigger && !st_reg.running |-> st_reg.count == CNT_IDLE)
      else $error("first trigger not from idle count");
   first_keep_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      trigger && !st_reg.running |=>
      half_duty_output == $past(half_duty_output))
      else $error("first start toggled half duty output");
   soft_trig_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      mode_on && count_tick && st_reg.soft_pend |-> trigger)
      else $error("soft trigger not taken");

   // Counting and matches
   count_step_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      count_step_s |=> st_reg.count == $past(st_reg.count) + 16'h0001)
      else $error("counter did not step by one");
   cyc_flag_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      count_step_s ##0 st_reg.count + 16'h0001 == st_reg.cycle_buf
      |=> st_reg.cyc_hit)
      else $error("cycle match not noted");
   cyc_single_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      cycle_match_irq |=> !cycle_match_irq)
      else $error("cycle irq longer than one cycle");
   width_low_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      count_step_s ##0 st_reg.count + 16'h0001 == st_reg.width_buf
      |=> !pulse_output && width_match_irq)
      else $error("width match did not drop pulse output");
   width_fall_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      width_match_irq && st_reg.count != CNT_ZERO |-> $fell(pulse_output))
      else $error("width irq apart from output change");

   // Buffer transfer only when armed, only at the clear
   buf_load_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      cyc_hit_s ##0 st_reg.armed |=>
      st_reg.width_buf == $past(st_reg.width_cmp) &&
      st_reg.cycle_buf == $past(st_reg.cycle_cmp) && !st_reg.armed)
      else $error("armed buffers not loaded at clear");
   no_arm_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      cyc_hit_s ##0 !st_reg.armed |=>
      $stable(st_reg.width_buf) && $stable(st_reg.cycle_buf))
      else $error("buffers loaded without width write");

   // Duty corner cases
   zero_both_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      cyc_hit_s ##0 st_reg.width_buf == CNT_ZERO |=>
      cycle_match_irq && width_match_irq)
      else $error("zero width irqs not together");
   zero_low_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      mode_on && st_reg.running && !st_reg.armed &&
      st_reg.width_buf == CNT_ZERO |=> !pulse_output)
      else $error("pulse output active at zero width");
   full_start_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      cyc_hit_s ##0 !st_reg.armed && st_reg.width_buf != CNT_ZERO |=>
      pulse_output)
      else $error("pulse output low after clear");
   // Wrap of cycle plus one to zero rules out full duty at FFFFH
   full_hold_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      mode_on && st_reg.running && !st_reg.armed && pulse_output &&
      st_reg.cycle_buf != CNT_ZERO && st_reg.width_buf != CNT_ZERO &&
      st_reg.width_buf == st_reg.cycle_buf + 16'h0001 |=> pulse_output)
      else $error("full duty output dropped");

   // Half duty output
   soft_half_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      cyc_hit_s ##0 st_reg.soft_used |=>
      half_duty_output != $past(half_duty_output))
      else $error("half duty output missed cycle clear");
   half_hold_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      mode_on && !st_reg.soft_used && !trigger |=>
      half_duty_output == $past(half_duty_output))
      else $error("half duty output toggled without soft trigger");
endmodule : trig_pwm_timer

// file: design/trig_pwm_pkg.sv
// Constants for the triggered PWM timer channel
package trig_pwm_pkg;
   localparam logic [2:0]  MODE_TRIG_PWM   = 3'h2;
   localparam logic [15:0] CNT_IDLE        = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO        = 16'h0000;
   localparam logic [15:0] CMP_RESET       = 16'hFFFF;
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL0       = 8'h00;
   localparam logic [7:0]  OFS_CTRL1       = 8'h04;
   localparam logic [7:0]  OFS_CYCLE       = 8'h08;
   localparam logic [7:0]  OFS_WIDTH       = 8'h0C;
   localparam logic [7:0]  OFS_STATUS      = 8'h10;
   localparam logic [7:0]  OFS_COUNT       = 8'h14;
   // Control register zero fields
   localparam int          CTL0_MODE_LSB   = 0;
   localparam int          CTL0_ENABLE_BIT = 7;
   // Control register one fields
   localparam int          CTL1_SOFT_TRIG  = 0;
   localparam int          CTL1_EDGE_LSB   = 1;
   // Edge select codes
   localparam logic [1:0]  EDGE_NONE       = 2'h0;
   localparam logic [1:0]  EDGE_RISE       = 2'h1;
   localparam logic [1:0]  EDGE_FALL       = 2'h2;
   localparam logic [1:0]  EDGE_BOTH       = 2'h3;
   // Status register fields
   localparam int          STAT_RUN_BIT    = 0;
   localparam int          STAT_ARMED_BIT  = 1;
   localparam int          STAT_PULSE_BIT  = 2;
   localparam int          STAT_HALF_BIT   = 3;
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
   localparam logic [2:0]  HSIZE_WORD      = 3'h2;
endpackage : trig_pwm_pkg

// file: verification/trig_pwm_partner.sv
// Trigger source and PWM load model
`timescale 1ns/10ps
module trig_pwm_partner (
   // Clock and command
   input  wire logic        hclk,
   input  wire logic        fire,
   // Pins
   input  wire logic        pulse_output,
   output logic             ext_trigger_input,
   output logic [15:0]      high_len
);
   logic [15:0] run_cnt;
   logic [1:0]  hold_cnt;
   initial begin
      ext_trigger_input = 1'b0;
      high_len = 16'h0000;
      run_cnt = 16'h0000;
      hold_cnt = 2'h0;
   end
   // Held high several clocks so the synchroniser cannot miss it
   always @(posedge hclk) begin
      if (fire) begin
         ext_trigger_input <= 1'b1;
         hold_cnt <= 2'h3;
      end else if (hold_cnt != 2'h0) begin
         hold_cnt <= hold_cnt - 2'h1;
      end else begin
         ext_trigger_input <= 1'b0;
      end
      // Load keeps the length of the last active stretch
      if (pulse_output) begin
         run_cnt <= run_cnt + 16'h0001;
      end else if (run_cnt != 16'h0000) begin
         high_len <= run_cnt;
         run_cnt <= 16'h0000;
      end
   end
endmodule : trig_pwm_partner

// file: verification/tb_top.sv
// Self-checking bench for the triggered PWM timer
`timescale 1ns/10ps
module tb_top;
   import trig_pwm_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, fire, half_q, h0, both_q;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, hrdata, rd;
   logic        hreadyout, hresp, pulse_output, half_duty_output;
   logic        ext_trigger_input, cycle_match_irq, width_match_irq;
   logic [15:0] high_len, gap, last_gap, hgap, last_hgap, cyc, wid;
   int          bad_count, tests_run;

   trig_pwm_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .count_tick(1'b1),
      .ext_trigger_input(ext_trigger_input), .pulse_output(pulse_output),
      .half_duty_output(half_duty_output),
      .cycle_match_irq(cycle_match_irq), .width_match_irq(width_match_irq));
   trig_pwm_partner far (.hclk(hclk), .fire(fire),
      .pulse_output(pulse_output), .ext_trigger_input(ext_trigger_input),
      .high_len(high_len));

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   // Spacing of cycle events and half-duty edges
   always @(posedge hclk) begin
      gap <= cycle_match_irq ? 16'h0000 : gap + 16'h0001;
      hgap <= (half_duty_output != half_q) ? 16'h0000 : hgap + 16'h0001;
      half_q <= half_duty_output;
      if (cycle_match_irq) begin
         last_gap <= gap + 16'h0001;
         both_q <= width_match_irq;
      end
      if (half_duty_output != half_q) last_hgap <= hgap + 16'h0001;
   end

   function automatic logic [31:0] period(input logic [15:0] c);
      return {16'h0000, c} + 32'h0000_0001;
   endfunction : period

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      hwrite <= w;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge hclk iff cycle_match_irq === 1'b1);
      #1;
   endtask : wait_cyc

   task automatic trig;
      fire <= 1'b1;
      @(posedge hclk);
      fire <= 1'b0;
   endtask : trig

   task automatic finish_test;
      if (bad_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test

   // Longest wait is three periods of the lengthened cycle
   initial begin
      repeat (20000) @(posedge hclk);
      bad_count++;
      finish_test();
   end

   initial begin
      void'($urandom(88164));
      {hresetn, hsel, hwrite, fire, half_q, both_q} = 6'h00;
      {haddr, htrans, hwdata} = 42'h0;
      {gap, hgap, last_gap, last_hgap} = 64'h0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("pulse rst", 32'h0, {31'h0, pulse_output});
      bus(1'b0, OFS_WIDTH, 32'h0);
      chk("width rst", 32'h0000_FFFF, rd);
      bus(1'b0, 8'hFC, 32'h0);
      chk("unmapped", 32'h0, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
      cyc = 16'h0004 + 16'($urandom % 12);
      wid = 16'h0001 + 16'($urandom % (cyc - 16'h0001));
      bus(1'b1, OFS_CYCLE, {16'h0, cyc});
      bus(1'b1, OFS_WIDTH, {16'h0, wid});
      bus(1'b1, OFS_CTRL1, {29'h0, EDGE_RISE, 1'b0});
      bus(1'b1, OFS_CTRL0, 32'h0000_0082);
      bus(1'b0, OFS_COUNT, 32'h0);
      chk("idle count", 32'h0000_FFFF, rd);
      trig();
      wait_cyc(3);
      chk("period", period(cyc), {16'h0, last_gap});
      chk("active", {16'h0, wid}, {16'h0, high_len});
      h0 = half_duty_output;
      trig();
      repeat (8) @(posedge hclk);
      chk("half restart", {31'h0, ~h0}, {31'h0, half_duty_output});
      bus(1'b1, OFS_CYCLE, {16'h0, cyc + 16'h0003});
      wait_cyc(2);
      chk("no load", period(cyc), {16'h0, last_gap});
      bus(1'b1, OFS_WIDTH, {16'h0, wid});
      wait_cyc(3);
      chk("load", period(cyc + 16'h0003), {16'h0, last_gap});
      bus(1'b1, OFS_CTRL1, {29'h0, EDGE_RISE, 1'b1});
      wait_cyc(3);
      chk("half per", period(cyc + 16'h0003), {16'h0, last_hgap});
      bus(1'b1, OFS_WIDTH, 32'h0);
      wait_cyc(2);
      chk("both irq", 32'h1, {31'h0, both_q});
      chk("zero duty", 32'h0, {31'h0, pulse_output});
      finish_test();
   end
endmodule : tb_top
